//--- include/dsoh_map.svh
`ifndef DSOH_MAP_SVH
`define DSOH_MAP_SVH

// Overhead positions in one sequence, per framing mode
`define DSOH_SEQ_DS3 6'h38
`define DSOH_SEQ_G751 6'h0C
`define DSOH_SEQ_G832 6'h38
`define DSOH_POS_FIRST 6'h00

// Link clock cycles per half period of each overhead clock
`define DSOH_HALF_CYC 3'h4

// Words held between the framer and the overhead pins
`define DSOH_FIFO_DEPTH 8

// Reset values
`define DSOH_CLK_IDLE 1'h1
`define DSOH_SOF_RST 1'h0

`endif

//--- include/dsoh_pkg.sv
package dsoh_pkg;

	// Framing mode of the channel; the port idles when unframed
	typedef enum logic [1:0] {
		DSOH_OFF = 2'b00,
		DSOH_DS3 = 2'b01,
		DSOH_G751 = 2'b10,
		DSOH_G832 = 2'b11
	} dsoh_mode_e;

	// Phase of a generated overhead clock
	typedef enum logic {
		DSOH_HI = 1'b0,
		DSOH_LO = 1'b1
	} dsoh_ph_e;

	// One overhead bit with its marker and overwrite enable
	typedef struct packed {
		logic first;
		logic en;
		logic data;
	} dsoh_word_s;

	// Per-signal polarity inversion of the overhead pins
	typedef struct packed {
		logic tx_data;
		logic tx_en;
		logic tx_clk;
		logic tx_sof;
		logic rx_data;
		logic rx_clk;
		logic rx_sof;
	} dsoh_inv_s;

endpackage : dsoh_pkg

//--- rtl/dsoh_port.sv
// Function
// R1: Transmit overhead bit is replaced by pin data only when overwrite enable is set.
// R2: DS3 transmit sequence holds the X, P, M, F and C positions.
// R3: G.751 transmit sequence holds all alignment, alarm and national bits.
// R4: G.832 transmit sequence holds FA1, FA2, EM, TR, MA, NR and GC bytes.
// R5: Transmit data and enable sampled, marker updated, on transmit clock falling edge.
// R6: Far logic samples marker and changes data and enable on rising edge.
// R7: Transmit marker flags the first overhead bit of each sequence.
// R8: Transmit sequence begins on the falling edge where the marker is high.
// R9: Low-rate transmit overhead clock runs whenever a framed mode is selected; here it stalls high while the transmit FIFO is full.
// R10: DS3 receive X, P, M, F and C bits go out serially.
// R11: In M23 mode the C bits are still delivered on receive.
// R12: G.751 receive alignment, alarm and national bits go out.
// R13: G.832 receive FA1, FA2, EM, TR, MA, NR and GC bytes go out.
// R14: Receive data and marker change only on receive clock falling edges.
// R15: Far logic captures receive data and marker on the rising edge.
// R16: Receive marker flags the first received overhead bit.
// R17: Receive sequence begins on the falling edge where the marker is high.
// R18: Each overhead pin and clock has its own polarity inversion.
`include "dsoh_map.svh"

module dsoh_fifo #(
	parameter int W = 3,
	parameter int D = `DSOH_FIFO_DEPTH
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_in_vld,
	input wire logic [W-1:0] i_in,
	output logic o_in_rdy,
	output logic o_out_vld,
	output logic [W-1:0] o_out,
	input wire logic i_out_rdy
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	localparam int CW = $clog2(D + 1);
	localparam logic [AW-1:0] LAST = AW'(D - 1);
	localparam logic [CW-1:0] FULL = CW'(D);

	logic [W-1:0] mem [D];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [CW-1:0] cnt_reg;
	logic rdy_reg;
	logic vld_reg;
	wire push;
	wire pop;
	wire [CW-1:0] cnt_next;

	// Flags are flops so that both ends see clean handshake levels
	assign push = i_in_vld && rdy_reg;
	assign pop = vld_reg && i_out_rdy;
	assign cnt_next = cnt_reg + CW'(push) - CW'(pop);
	assign o_in_rdy = rdy_reg;
	assign o_out_vld = vld_reg;
	assign o_out = mem[rd_reg];

	// Storage carries no reset; only pointers define content
	always_ff @(posedge i_clk)
	begin
		if (push)
			mem[wr_reg] <= i_in;
	end

	// Pointers and honest full and empty flags
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
			rdy_reg <= 1'b1;
			vld_reg <= 1'b0;
		end
		else
		begin
			if (push)
				wr_reg <= (wr_reg == LAST) ? '0 : wr_reg + 1'b1;
			if (pop)
				rd_reg <= (rd_reg == LAST) ? '0 : rd_reg + 1'b1;
			cnt_reg <= cnt_next;
			rdy_reg <= cnt_next != FULL;
			vld_reg <= cnt_next != '0;
		end
	end

	fifo_full_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(cnt_reg == FULL) |-> !o_in_rdy)
		else $error("fifo accepts while full");

endmodule : dsoh_fifo

module dsoh_port (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_lclk,
	input dsoh_pkg::dsoh_mode_e i_mode,
	input dsoh_pkg::dsoh_inv_s i_inv,
	input wire logic i_tx_slot,
	input wire logic i_tx_orig,
	output logic o_tx_bit,
	output logic o_tx_bit_vld,
	output logic o_tx_first,
	output logic o_tx_miss,
	input wire logic i_rx_vld,
	input wire logic i_rx_bit,
	input wire logic i_rx_first,
	output logic o_rx_rdy,
	input wire logic i_tx_overhead_data_in,
	input wire logic i_tx_overhead_overwrite_en,
	output logic o_tx_overhead_clk_out,
	output logic o_tx_overhead_seq_start,
	output logic o_rx_overhead_data_out,
	output logic o_rx_overhead_clk_out,
	output logic o_rx_overhead_seq_start
);
	localparam int LS = 13;
	localparam int WW = $bits(dsoh_pkg::dsoh_word_s);

	// Core domain state
	logic [1:0] cs1_reg;
	logic [1:0] cs2_reg;
	logic tack_reg;
	logic rreq_reg;
	dsoh_pkg::dsoh_word_s rxfer_reg;
	logic tbit_reg;
	logic tvld_reg;
	logic tfirst_reg;
	logic tmiss_reg;
	// Link domain state
	logic lrst1_reg;
	logic lrst_reg;
	logic [LS-1:0] ls1_reg;
	logic [LS-1:0] ls2_reg;
	dsoh_pkg::dsoh_ph_e tph_reg;
	logic [2:0] tcnt_reg;
	logic [5:0] tpos_reg;
	logic tsof_reg;
	logic thave_reg;
	logic treq_reg;
	dsoh_pkg::dsoh_word_s thold_reg;
	dsoh_pkg::dsoh_ph_e rph_reg;
	logic [2:0] rcnt_reg;
	logic rdat_reg;
	logic rsof_reg;
	logic rack_reg;
	logic rbuf_vld_reg;
	dsoh_pkg::dsoh_word_s rbuf_reg;
	logic txc_reg;
	logic txs_reg;
	logic rxc_reg;
	logic rxd_reg;
	logic rxs_reg;

	// Core side decode
	wire treq_s;
	wire rack_s;
	wire tpend;
	wire rpend;
	wire tf_rdy;
	wire tf_vld;
	dsoh_pkg::dsoh_word_s tf_out;
	wire rf_in_vld;
	dsoh_pkg::dsoh_word_s rf_in;
	wire rf_vld;
	dsoh_pkg::dsoh_word_s rf_out;
	wire rx_pop;
	wire tx_ovw;

	// Link side decode
	wire [LS-1:0] lsync_in;
	dsoh_pkg::dsoh_mode_e lmode;
	dsoh_pkg::dsoh_inv_s linv;
	wire rreq_s;
	wire tack_s;
	wire pin_data;
	wire pin_en;
	wire lframed;
	wire [5:0] tx_len;
	wire [5:0] tpos_inc;
	wire thd;
	wire rhd;
	wire tx_fall;
	wire tx_rise;
	wire rx_fall;
	wire rx_rise;
	wire rx_take;
	dsoh_pkg::dsoh_ph_e tph_next;
	dsoh_pkg::dsoh_ph_e rph_next;
	wire tsof_next;
	wire rdat_next;
	wire rsof_next;

	// Core synchronisers for the two link toggles
	always_ff @(posedge i_clk)
	begin
		cs1_reg <= {treq_reg, rack_reg};
		cs2_reg <= cs1_reg;
	end

	assign treq_s = cs2_reg[1];
	assign rack_s = cs2_reg[0];
	assign tpend = treq_s != tack_reg;
	assign rpend = rreq_reg != rack_s;

	// Sampled words wait here; when full the transmit overhead clock stalls high
	dsoh_fifo #(.W(WW), .D(`DSOH_FIFO_DEPTH)) u_tx_fifo (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_in_vld(tpend),
		.i_in(thold_reg),
		.o_in_rdy(tf_rdy),
		.o_out_vld(tf_vld),
		.o_out(tf_out),
		.i_out_rdy(i_tx_slot)
	);

	// Framer offers every overhead bit of the mode, C bits too in M23
	assign rf_in_vld = i_rx_vld && (i_mode != dsoh_pkg::DSOH_OFF); // R10 R11 R12 R13
	assign rf_in = '{first: i_rx_first, en: 1'b1, data: i_rx_bit};
	assign rx_pop = rf_vld && !rpend;
	assign tx_ovw = tf_vld && tf_out.en;

	// Received bits queue here; o_rx_rdy drops when it is full
	dsoh_fifo #(.W(WW), .D(`DSOH_FIFO_DEPTH)) u_rx_fifo (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_in_vld(rf_in_vld),
		.i_in(rf_in),
		.o_in_rdy(o_rx_rdy),
		.o_out_vld(rf_vld),
		.o_out(rf_out),
		.i_out_rdy(!rpend)
	);

	// Acknowledge a link word only once the FIFO has taken it
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			tack_reg <= 1'b0;
		else if (tpend && tf_rdy)
			tack_reg <= treq_s;
	end

	// Word stays still while its toggle is outstanding
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			rreq_reg <= 1'b0;
		else if (rx_pop)
			rreq_reg <= !rreq_reg;
		if (rx_pop)
			rxfer_reg <= rf_out;
	end

	// Overwrite only when enabled; an empty queue keeps the framer bit
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			tbit_reg <= 1'b0;
			tvld_reg <= 1'b0;
			tfirst_reg <= 1'b0;
			tmiss_reg <= 1'b0;
		end
		else
		begin
			tbit_reg <= tx_ovw ? tf_out.data : i_tx_orig; // R1
			tvld_reg <= i_tx_slot;
			tfirst_reg <= i_tx_slot && tf_vld && tf_out.first;
			tmiss_reg <= i_tx_slot && !tf_vld;
		end
	end

	assign o_tx_bit = tbit_reg;
	assign o_tx_bit_vld = tvld_reg;
	assign o_tx_first = tfirst_reg;
	assign o_tx_miss = tmiss_reg;

	tx_overwrite_a: assert property (@(posedge i_clk) disable iff (i_rst) // R1
		(i_tx_slot && tx_ovw) |=> (o_tx_bit == $past(tf_out.data)))
		else $error("enabled overhead bit not overwritten");

	tx_keep_a: assert property (@(posedge i_clk) disable iff (i_rst) // R1
		(i_tx_slot && !tx_ovw) |=> (o_tx_bit == $past(i_tx_orig)))
		else $error("overhead bit overwritten without enable");

	rx_off_a: assert property (@(posedge i_clk) disable iff (i_rst) // R10
		(i_mode == dsoh_pkg::DSOH_OFF) |-> !rf_in_vld)
		else $error("receive overhead taken while unframed");

	// Link reset follows the core reset through two flops
	always_ff @(posedge i_lclk)
	begin
		lrst1_reg <= i_rst;
		lrst_reg <= lrst1_reg;
	end

	// Mode, inversion, toggles and pins all cross by two flops
	assign lsync_in = {i_mode, i_inv, rreq_reg, tack_reg, i_tx_overhead_data_in, i_tx_overhead_overwrite_en};

	generate
		for (genvar g = 0; g < LS; g++)
		begin : g_lsync
			always_ff @(posedge i_lclk)
			begin
				ls1_reg[g] <= lsync_in[g];
				ls2_reg[g] <= ls1_reg[g];
			end
		end
	endgenerate

	assign lmode = dsoh_pkg::dsoh_mode_e'(ls2_reg[12:11]);
	assign linv = dsoh_pkg::dsoh_inv_s'(ls2_reg[10:4]);
	assign rreq_s = ls2_reg[3];
	assign tack_s = ls2_reg[2];
	assign pin_data = ls2_reg[1] ^ linv.tx_data; // R18
	assign pin_en = ls2_reg[0] ^ linv.tx_en; // R18

	// Sequence length per mode; positions beyond the last wrap to the first
	assign lframed = lmode != dsoh_pkg::DSOH_OFF;
	assign tx_len = (lmode == dsoh_pkg::DSOH_G751) ? `DSOH_SEQ_G751 : // R3
		(lmode == dsoh_pkg::DSOH_G832) ? `DSOH_SEQ_G832 : // R4
		`DSOH_SEQ_DS3; // R2
	assign tpos_inc = (tpos_reg == tx_len - 6'h01) ? `DSOH_POS_FIRST : tpos_reg + 6'h01;

	// Clock edges; a fall waits until the core took the last sample
	assign thd = tcnt_reg == (`DSOH_HALF_CYC - 3'h1);
	assign rhd = rcnt_reg == (`DSOH_HALF_CYC - 3'h1);
	assign tx_fall = lframed && (tph_reg == dsoh_pkg::DSOH_HI) && thd && (treq_reg == tack_s); // R9
	assign tx_rise = (tph_reg == dsoh_pkg::DSOH_LO) && thd;
	assign rx_fall = lframed && (rph_reg == dsoh_pkg::DSOH_HI) && rhd && rbuf_vld_reg;
	assign rx_rise = (rph_reg == dsoh_pkg::DSOH_LO) && rhd;
	assign rx_take = (rreq_s != rack_reg) && !rbuf_vld_reg;

	// Next phase and pin values; unframed holds both clocks idle
	assign tph_next = (lrst_reg || !lframed) ? dsoh_pkg::DSOH_HI :
		tx_fall ? dsoh_pkg::DSOH_LO : tx_rise ? dsoh_pkg::DSOH_HI : tph_reg; // R9
	assign rph_next = (lrst_reg || !lframed) ? dsoh_pkg::DSOH_HI :
		rx_fall ? dsoh_pkg::DSOH_LO : rx_rise ? dsoh_pkg::DSOH_HI : rph_reg;
	assign tsof_next = (lrst_reg || !lframed) ? `DSOH_SOF_RST :
		tx_fall ? (tpos_reg == `DSOH_POS_FIRST) : tsof_reg; // R5 R7 R8
	assign rdat_next = rx_fall ? rbuf_reg.data : rdat_reg; // R14
	assign rsof_next = lrst_reg ? `DSOH_SOF_RST : rx_fall ? rbuf_reg.first : rsof_reg; // R14 R16 R17

	// Transmit half-period counter and position
	always_ff @(posedge i_lclk)
	begin
		tph_reg <= tph_next;
		tsof_reg <= tsof_next;
		if (lrst_reg || !lframed || tx_fall || tx_rise)
			tcnt_reg <= 3'h0;
		else if (!thd)
			tcnt_reg <= tcnt_reg + 3'h1;
		if (lrst_reg || !lframed)
			tpos_reg <= `DSOH_POS_FIRST;
		else if (tx_fall)
			tpos_reg <= tpos_inc;
	end

	// Sample taken at a fall belongs to the position marked one fall before
	always_ff @(posedge i_lclk)
	begin
		if (lrst_reg || !lframed)
			thave_reg <= 1'b0;
		else if (tx_fall)
			thave_reg <= 1'b1;
		if (lrst_reg)
			treq_reg <= 1'b0;
		else if (tx_fall && thave_reg)
			treq_reg <= !treq_reg;
		if (tx_fall && thave_reg)
			thold_reg <= '{first: tsof_reg, en: pin_en, data: pin_data}; // R5
	end

	// Receive clock is gapped: it only falls when a bit is waiting
	always_ff @(posedge i_lclk)
	begin
		rph_reg <= rph_next;
		rdat_reg <= rdat_next;
		rsof_reg <= rsof_next;
		if (lrst_reg || !lframed || rx_fall || rx_rise)
			rcnt_reg <= 3'h0;
		else if (!rhd)
			rcnt_reg <= rcnt_reg + 3'h1;
	end

	// One-word landing buffer for the core handshake
	always_ff @(posedge i_lclk)
	begin
		if (lrst_reg)
		begin
			rack_reg <= 1'b0;
			rbuf_vld_reg <= 1'b0;
		end
		else if (rx_take)
		begin
			rack_reg <= rreq_s;
			rbuf_vld_reg <= 1'b1;
		end
		else if (rx_fall)
			rbuf_vld_reg <= 1'b0;
		if (rx_take)
			rbuf_reg <= rxfer_reg;
	end

	// Pin flops carry the inversion so outputs come straight from flops
	always_ff @(posedge i_lclk)
	begin
		txc_reg <= (tph_next == dsoh_pkg::DSOH_HI) ^ linv.tx_clk; // R18
		txs_reg <= tsof_next ^ linv.tx_sof; // R18
		rxc_reg <= (rph_next == dsoh_pkg::DSOH_HI) ^ linv.rx_clk; // R18
		rxd_reg <= rdat_next ^ linv.rx_data; // R18
		rxs_reg <= rsof_next ^ linv.rx_sof; // R18
	end

	assign o_tx_overhead_clk_out = txc_reg;
	assign o_tx_overhead_seq_start = txs_reg;
	assign o_rx_overhead_clk_out = rxc_reg;
	assign o_rx_overhead_data_out = rxd_reg;
	assign o_rx_overhead_seq_start = rxs_reg;

	sequence s_tx_low;
		(tph_reg == dsoh_pkg::DSOH_LO) [*4];
	endsequence

	property p_wrap(dsoh_pkg::dsoh_mode_e m, logic [5:0] len);
		@(posedge i_lclk) disable iff (lrst_reg)
		(tx_fall && lmode == m && tpos_reg == len - 6'h01) |=> (tpos_reg == `DSOH_POS_FIRST);
	endproperty

	tx_ds3_len_a: assert property (p_wrap(dsoh_pkg::DSOH_DS3, `DSOH_SEQ_DS3)) // R2
		else $error("DS3 sequence length wrong");

	tx_g751_len_a: assert property (p_wrap(dsoh_pkg::DSOH_G751, `DSOH_SEQ_G751)) // R3
		else $error("G.751 sequence length wrong");

	tx_g832_len_a: assert property (p_wrap(dsoh_pkg::DSOH_G832, `DSOH_SEQ_G832)) // R4
		else $error("G.832 sequence length wrong");

	tx_sample_a: assert property (@(posedge i_lclk) disable iff (lrst_reg) // R5
		(tx_fall && thave_reg) |=> (thold_reg == {$past(tsof_reg), $past(pin_en), $past(pin_data)}))
		else $error("transmit sample not taken at falling edge");

	tx_sof_edge_a: assert property (@(posedge i_lclk) disable iff (lrst_reg) // R5
		($changed(tsof_reg) && lframed) |-> $past(tx_fall))
		else $error("transmit marker moved off a falling edge");

	tx_first_a: assert property (@(posedge i_lclk) disable iff (lrst_reg) // R7
		$rose(tsof_reg) |-> ($past(tpos_reg) == `DSOH_POS_FIRST))
		else $error("transmit marker not on first position");

	tx_seq_start_a: assert property (@(posedge i_lclk) disable iff (lrst_reg) // R8
		(tx_fall && tpos_reg == `DSOH_POS_FIRST) |=> (tsof_reg && tph_reg == dsoh_pkg::DSOH_LO))
		else $error("sequence start not with marker on fall");

	tx_low_len_a: assert property (@(posedge i_lclk) disable iff (lrst_reg || !lframed) // R9
		(tx_fall && lframed) |=> s_tx_low ##1 (tph_reg == dsoh_pkg::DSOH_HI || !lframed))
		else $error("transmit clock low phase wrong length");

	rx_change_a: assert property (@(posedge i_lclk) disable iff (lrst_reg) // R14
		($changed(rdat_reg) || $changed(rsof_reg)) |-> $past(rx_fall))
		else $error("receive output moved off a falling edge");

	rx_first_a: assert property (@(posedge i_lclk) disable iff (lrst_reg) // R16 R17
		rx_fall |=> (rsof_reg == $past(rbuf_reg.first) && rph_reg == dsoh_pkg::DSOH_LO))
		else $error("receive marker not with its bit");

	pin_inv_a: assert property (@(posedge i_lclk) disable iff (lrst_reg) // R18
		$stable(linv) |=> (o_tx_overhead_clk_out == ((tph_reg == dsoh_pkg::DSOH_HI) ^ $past(linv.tx_clk))))
		else $error("transmit clock polarity wrong");

endmodule : dsoh_port

//--- testbench/dsoh_far_model.sv
// Far-end overhead logic: feeds the transmit overhead pins and captures the receive ones
module dsoh_far_model (
	input wire logic i_lclk,
	input wire logic i_slow,
	input dsoh_pkg::dsoh_inv_s i_inv,
	input wire logic i_tx_clk,
	input wire logic i_tx_sof,
	input wire logic i_rx_clk,
	input wire logic i_rx_data,
	input wire logic i_rx_sof,
	output logic o_tx_data,
	output logic o_tx_en
);
	timeunit 1ns;
	timeprecision 100ps;

	// Pin levels as this side sees them, with the port's inversion undone
	wire logic tx_clk_seen = i_tx_clk ^ i_inv.tx_clk;
	wire logic rx_clk_seen = i_rx_clk ^ i_inv.rx_clk;
	logic [5:0] pos = 6'h00;
	logic sof_now;
	logic [1:0] pat;
	logic [1:0] rx_q[$];
	int tx_falls = 0;

	// Enable and data wanted at one position; en toggles in pairs so a shifted position shows up
	function automatic logic [1:0] tx_pattern(input logic [5:0] p);
		return {p[0] ^ p[1], p[0] ^ p[2]};
	endfunction : tx_pattern

	// Pins start at a known level before the first rise
	initial
	begin
		o_tx_data = 1'h0;
		o_tx_en = 1'h0;
	end

	// Marker taken on the rise, pins moved right after it; slow mode answers one link cycle late
	always @(posedge tx_clk_seen)
	begin
		sof_now = i_tx_sof ^ i_inv.tx_sof;
		if (i_slow)
			@(posedge i_lclk);
		pos = sof_now ? 6'h00 : pos + 6'h01;
		pat = tx_pattern(pos);
		o_tx_en <= pat[1] ^ i_inv.tx_en;
		o_tx_data <= pat[0] ^ i_inv.tx_data;
	end

	// Falls are counted so a parked clock can be told from a running one
	always @(negedge tx_clk_seen)
		tx_falls++;

	// Capture half a period after the port moved the lines
	always @(posedge rx_clk_seen)
		rx_q.push_back({i_rx_sof ^ i_inv.rx_sof, i_rx_data ^ i_inv.rx_data});
endmodule : dsoh_far_model

//--- testbench/tb_ds3_e3_overhead_port.sv
`include "dsoh_map.svh"

module tb_ds3_e3_overhead_port;
	timeunit 1ns;
	timeprecision 100ps;

	logic i_clk = 1'h0;
	logic i_lclk = 1'h0;
	logic i_rst = 1'h1;
	dsoh_pkg::dsoh_mode_e i_mode = dsoh_pkg::DSOH_OFF;
	dsoh_pkg::dsoh_inv_s i_inv = 7'h00;
	logic i_tx_slot = 1'h0;
	logic i_tx_orig = 1'h0;
	logic i_rx_vld = 1'h0;
	logic i_rx_bit = 1'h0;
	logic i_rx_first = 1'h0;
	logic far_slow = 1'h0;
	logic i_tx_overhead_data_in, i_tx_overhead_overwrite_en;
	logic o_tx_bit, o_tx_bit_vld, o_tx_first, o_tx_miss, o_rx_rdy;
	logic o_tx_overhead_clk_out, o_tx_overhead_seq_start;
	logic o_rx_overhead_data_out, o_rx_overhead_clk_out, o_rx_overhead_seq_start;
	int fails = 0;
	int checks_done = 0;

	// Core clock
	initial
	begin
		forever #5 i_clk = ~i_clk;
	end

	// Link clock, phase unrelated to the core clock
	initial
	begin
		#37;
		forever #62.5 i_lclk = ~i_lclk;
	end

	dsoh_port i_dut (.i_clk, .i_rst, .i_lclk, .i_mode, .i_inv, .i_tx_slot, .i_tx_orig, .o_tx_bit,
		.o_tx_bit_vld, .o_tx_first, .o_tx_miss, .i_rx_vld, .i_rx_bit, .i_rx_first, .o_rx_rdy,
		.i_tx_overhead_data_in, .i_tx_overhead_overwrite_en, .o_tx_overhead_clk_out,
		.o_tx_overhead_seq_start, .o_rx_overhead_data_out, .o_rx_overhead_clk_out,
		.o_rx_overhead_seq_start);

	dsoh_far_model i_far (.i_lclk, .i_slow(far_slow), .i_inv, .i_tx_clk(o_tx_overhead_clk_out),
		.i_tx_sof(o_tx_overhead_seq_start), .i_rx_clk(o_rx_overhead_clk_out),
		.i_rx_data(o_rx_overhead_data_out), .i_rx_sof(o_rx_overhead_seq_start),
		.o_tx_data(i_tx_overhead_data_in), .o_tx_en(i_tx_overhead_overwrite_en));

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : check

	task automatic final_report;
		if (fails == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report

	task automatic timed_out;
		check(8'h00, 8'h01);
		final_report();
	endtask : timed_out

	// Unframed: both overhead clocks park high and a received bit is dropped
	task automatic t_idle_off;
		int f0;
		i_mode <= dsoh_pkg::DSOH_OFF;
		repeat (300) @(posedge i_clk);
		i_far.rx_q.delete();
		f0 = i_far.tx_falls;
		i_rx_vld <= 1'h1;
		i_rx_first <= 1'h1;
		@(posedge i_clk);
		i_rx_vld <= 1'h0;
		repeat (300) @(posedge i_clk);
		check(8'(i_far.tx_falls - f0), 8'h00);
		check(8'(i_far.rx_q.size()), 8'h00);
		check(8'(o_tx_overhead_clk_out ^ i_inv.tx_clk), 8'h01);
		check(8'(o_rx_overhead_clk_out ^ i_inv.rx_clk), 8'h01);
	endtask : t_idle_off

	// Transmit: pins fill the queue, then slots pop words; length between markers is the sequence
	task automatic t_tx_mode(input dsoh_pkg::dsoh_mode_e m, input logic [7:0] len, input logic slow);
		int f0;
		int n;
		int cnt;
		int firsts;
		logic [1:0] pat;
		i_mode <= dsoh_pkg::DSOH_OFF;
		far_slow <= slow;
		repeat (200) @(posedge i_clk);
		// Words left from an earlier mode would carry stale positions
		repeat (12)
		begin
			i_tx_slot <= 1'h1;
			@(posedge i_clk);
			i_tx_slot <= 1'h0;
			@(posedge i_clk);
		end
		f0 = i_far.tx_falls;
		i_mode <= m;
		repeat (2000) @(posedge i_clk);
		check(8'(i_far.tx_falls > f0), 8'h01);
		n = 0;
		cnt = 0;
		firsts = 0;
		while (firsts < 2)
		begin
			n++;
			if (n > 400)
				timed_out();
			i_tx_slot <= 1'h1;
			i_tx_orig <= n[0];
			@(posedge i_clk);
			i_tx_slot <= 1'h0;
			#1;
			check(8'(o_tx_bit_vld), 8'h01);
			if (o_tx_miss === 1'h1)
				check(8'(o_tx_bit), 8'(n[0]));
			else
			begin
				if (o_tx_first === 1'h1)
				begin
					if (firsts > 0)
						check(8'(cnt), len);
					firsts++;
					cnt = 0;
				end
				pat = i_far.tx_pattern(6'(cnt));
				if (firsts > 0)
					check(8'(o_tx_bit), 8'(pat[1] ? pat[0] : n[0]));
				cnt++;
			end
			repeat (59) @(posedge i_clk);
		end
	endtask : t_tx_mode

	// Receive: push until the buffer refuses, then all accepted bits must come out in order
	task automatic t_rx_fill(input dsoh_pkg::dsoh_mode_e m);
		logic [1:0] sent[$];
		int k;
		logic rdy_seen;
		i_mode <= m;
		repeat (100) @(posedge i_clk);
		i_far.rx_q.delete();
		for (k = 0; k < 40; k++)
		begin
			i_rx_first <= (k == 0);
			i_rx_bit <= k[0] ^ k[2];
			i_rx_vld <= 1'h1;
			// Ready is read mid-cycle, where it stands for the coming edge
			@(negedge i_clk);
			rdy_seen = o_rx_rdy;
			@(posedge i_clk);
			if (rdy_seen !== 1'h1)
				break;
			sent.push_back({k == 0, k[0] ^ k[2]});
		end
		i_rx_vld <= 1'h0;
		check(8'(sent.size() >= 8 && k < 40), 8'h01);
		for (k = 0; k < 20000 && i_far.rx_q.size() < sent.size(); k++)
			@(posedge i_clk);
		if (k == 20000)
			timed_out();
		repeat (1000) @(posedge i_clk);
		check(8'(i_far.rx_q.size()), 8'(sent.size()));
		for (k = 0; k < sent.size(); k++)
			check(8'(i_far.rx_q[k]), 8'(sent[k]));
		check(8'(o_rx_rdy), 8'h01);
	endtask : t_rx_fill

	// Main sequence; reset spans four link cycles so the link side leaves reset too
	initial
	begin
		repeat (4) @(posedge i_lclk);
		@(posedge i_clk);
		i_rst <= 1'h0;
		repeat (40) @(posedge i_clk);
		t_idle_off();
		t_tx_mode(dsoh_pkg::DSOH_DS3, 8'(`DSOH_SEQ_DS3), 1'h0);
		t_rx_fill(dsoh_pkg::DSOH_DS3);
		t_tx_mode(dsoh_pkg::DSOH_G751, 8'(`DSOH_SEQ_G751), 1'h0);
		t_rx_fill(dsoh_pkg::DSOH_G751);
		t_tx_mode(dsoh_pkg::DSOH_G832, 8'(`DSOH_SEQ_G832), 1'h1);
		t_rx_fill(dsoh_pkg::DSOH_G832);
		i_inv <= 7'h7F;
		t_tx_mode(dsoh_pkg::DSOH_G751, 8'(`DSOH_SEQ_G751), 1'h0);
		t_rx_fill(dsoh_pkg::DSOH_G751);
		t_idle_off();
		final_report();
	end
endmodule : tb_ds3_e3_overhead_port
